// *** hw/sgmii_rx_elastic_buffer.sv ***
// SGMII receive elastic buffer: link sampling, idle deletion, output stage
`include "sgmii_eb_cfg.svh"

// Behaviour
// - Fabric buffer default; transceiver-buffer bypass optional
// - One RAM, 128 entries, 64 each side
// - Gap idles dropped while over half full
// - Tolerates one entry drift per 5000 bytes
// - Lower speeds replicate bytes 10 or 100 times
// - 1522-byte frames at all three speeds
// - Jumbo limits 280000, 28000, 2800 bytes
module sgmii_rx_elastic_buffer
   import sgmii_eb_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Recovered link
   input wire logic rec_clk,
   input wire logic [7:0] rx_data,
   input wire logic rx_is_k,
   // Mode and speed
   input wire logic use_xcvr_buffer,
   input wire logic [1:0] speed_sel,
   // Symbols to the MAC
   output logic [7:0] mac_data,
   output logic mac_is_k,
   output logic mac_valid,
   input wire logic mac_ready,
   // Status
   output logic [7:0] eb_occupancy,
   output logic [7:0] eb_occ_max,
   output logic [7:0] eb_occ_min,
   output logic eb_in_frame,
   output logic eb_idle_dropped,
   output logic eb_overflow,
   output logic eb_underflow,
   output logic eb_frame_jumbo,
   output logic eb_frame_too_long
);

   // Input synchronisers
   logic rec_clk_s1_r, rec_clk_s2_r, rec_clk_s3_r;
   logic [7:0] data_s1_r, data_s2_r;
   logic k_s1_r, k_s2_r, mode_s1_r, mode_s2_r;
   logic [1:0] speed_s1_r, speed_s2_r;

   // Symbol path and FIFO
   logic sym_stb, is_sop, is_end, is_idle, bypass;
   frame_state_t state_r;
   logic skip_r, drop_now, over_half, wr_req;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [8:0] fifo_out_data;
   logic [7:0] occ;

   // Frame length tracking
   logic [6:0] rep_len, rep_cnt_r;
   logic [18:0] jumbo_max, byte_cnt_r;

   // Output registers
   logic [7:0] mac_data_r, occ_out_r, occ_max_r, occ_min_r;
   logic mac_is_k_r, mac_valid_r, in_frame_r, idle_dropped_r;
   logic overflow_r, underflow_r, jumbo_r, too_long_r;

   // The first stage of each synchroniser feeds only the second
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rec_clk_s1_r <= 1'b0;
         rec_clk_s2_r <= 1'b0;
         rec_clk_s3_r <= 1'b0;
         data_s1_r <= 8'h00;
         data_s2_r <= 8'h00;
         k_s1_r <= 1'b0;
         k_s2_r <= 1'b0;
         mode_s1_r <= 1'b0;
         mode_s2_r <= 1'b0;
         speed_s1_r <= 2'h0;
         speed_s2_r <= 2'h0;
      end
      else
      begin
         rec_clk_s1_r <= rec_clk;
         rec_clk_s2_r <= rec_clk_s1_r;
         rec_clk_s3_r <= rec_clk_s2_r;
         data_s1_r <= rx_data;
         data_s2_r <= data_s1_r;
         k_s1_r <= rx_is_k;
         k_s2_r <= k_s1_r;
         mode_s1_r <= use_xcvr_buffer;
         mode_s2_r <= mode_s1_r;
         speed_s1_r <= speed_sel;
         speed_s2_r <= speed_s1_r;
      end
   end

   // One strobe per recovered-clock rising edge
   assign sym_stb = rec_clk_s2_r && !rec_clk_s3_r;
   assign is_sop = k_s2_r && (data_s2_r == `SYM_SOP);
   assign is_end = k_s2_r && ((data_s2_r == `SYM_EOP) || (data_s2_r == `SYM_ERR));
   assign is_idle = k_s2_r && (data_s2_r == `SYM_IDLE);
   assign bypass = mode_s2_r;

   // Decode the speed; unused code falls back to 1 Gbps
   always_comb
   begin
      rep_len = `REP_1G;
      jumbo_max = `JUMBO_MAX_1G;
      if (speed_s2_r == 2'h1)
      begin
         rep_len = `REP_100M;
         jumbo_max = `JUMBO_MAX_100M;
      end
      else if (speed_s2_r == 2'h2)
      begin
         rep_len = `REP_10M;
         jumbo_max = `JUMBO_MAX_10M;
      end
   end

   // Frame tracking between start and end delimiters
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_GAP;
      end
      else if (sym_stb)
      begin
         case (state_r)
            ST_GAP:
            begin
               if (is_sop)
               begin
                  state_r <= ST_FRAME;
               end
            end
            ST_FRAME:
            begin
               if (is_end)
               begin
                  state_r <= ST_GAP;
               end
            end
            default:
            begin
               state_r <= ST_GAP;
            end
         endcase
      end
   end

   // Idle deletion removes the whole two-symbol idle to keep lane parity
   assign over_half = (occ > `EB_HALF);
   assign drop_now = sym_stb && (state_r == ST_GAP) && is_idle && over_half && !skip_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         skip_r <= 1'b0;
      end
      else if (sym_stb)
      begin
         skip_r <= drop_now;
      end
   end

   // Replicated symbols at lower speeds are stored one by one
   assign wr_req = sym_stb && !bypass && !drop_now && !skip_r;

   elastic_fifo #(
      .WIDTH(`EB_WIDTH),
      .DEPTH(`EB_DEPTH),
      .AW(`EB_AW)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(wr_req),
      .in_data({k_s2_r, data_s2_r}),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_out_ready),
      .occupancy(occ)
   );

   assign fifo_out_ready = !bypass && (!mac_valid_r || mac_ready);

   // Output stage; bypass passes each sampled symbol for one cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mac_data_r <= 8'h00;
         mac_is_k_r <= 1'b0;
         mac_valid_r <= 1'b0;
      end
      else if (bypass)
      begin
         mac_valid_r <= sym_stb;
         mac_data_r <= data_s2_r;
         mac_is_k_r <= k_s2_r;
      end
      else if (!mac_valid_r || mac_ready)
      begin
         mac_valid_r <= fifo_out_valid;
         mac_data_r <= fifo_out_data[7:0];
         mac_is_k_r <= fifo_out_data[8];
      end
   end

   // Error and event pulses
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         idle_dropped_r <= 1'b0;
         overflow_r <= 1'b0;
         underflow_r <= 1'b0;
      end
      else
      begin
         idle_dropped_r <= drop_now;
         overflow_r <= wr_req && !fifo_in_ready;
         underflow_r <= !bypass && (state_r == ST_FRAME) && mac_ready && !fifo_out_valid
            && !mac_valid_r;
      end
   end

   // Occupancy and its in-frame watermarks
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         occ_out_r <= 8'h00;
         occ_max_r <= 8'h00;
         occ_min_r <= 8'h00;
         in_frame_r <= 1'b0;
      end
      else
      begin
         occ_out_r <= occ;
         in_frame_r <= (state_r == ST_FRAME);
         if (sym_stb && (state_r == ST_GAP) && is_sop)
         begin
            occ_max_r <= occ;
            occ_min_r <= occ;
         end
         else if (state_r == ST_FRAME)
         begin
            if (occ > occ_max_r)
            begin
               occ_max_r <= occ;
            end
            if (occ < occ_min_r)
            begin
               occ_min_r <= occ;
            end
         end
      end
   end

   // Frame length in bytes, one byte per replication group
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rep_cnt_r <= 7'h00;
         byte_cnt_r <= 19'h00000;
      end
      else if (sym_stb)
      begin
         if (state_r == ST_GAP)
         begin
            rep_cnt_r <= 7'h00;
            byte_cnt_r <= 19'h00000;
         end
         else if (rep_cnt_r == rep_len - 7'h01)
         begin
            rep_cnt_r <= 7'h00;
            if (byte_cnt_r != 19'h7ffff)
            begin
               byte_cnt_r <= byte_cnt_r + 19'h00001;
            end
         end
         else
         begin
            rep_cnt_r <= rep_cnt_r + 7'h01;
         end
      end
   end

   // Length flags hold from detection until the next frame starts
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         jumbo_r <= 1'b0;
         too_long_r <= 1'b0;
      end
      else if (sym_stb && (state_r == ST_GAP) && is_sop)
      begin
         jumbo_r <= 1'b0;
         too_long_r <= 1'b0;
      end
      else if (state_r == ST_FRAME)
      begin
         if (byte_cnt_r > `FRAME_STD_MAX)
         begin
            jumbo_r <= 1'b1;
         end
         if (byte_cnt_r > jumbo_max)
         begin
            too_long_r <= 1'b1;
         end
      end
   end

   assign mac_data = mac_data_r;
   assign mac_is_k = mac_is_k_r;
   assign mac_valid = mac_valid_r;
   assign eb_occupancy = occ_out_r;
   assign eb_occ_max = occ_max_r;
   assign eb_occ_min = occ_min_r;
   assign eb_in_frame = in_frame_r;
   assign eb_idle_dropped = idle_dropped_r;
   assign eb_overflow = overflow_r;
   assign eb_underflow = underflow_r;
   assign eb_frame_jumbo = jumbo_r;
   assign eb_frame_too_long = too_long_r;

endmodule : sgmii_rx_elastic_buffer

// *** pkg/sgmii_eb_cfg.svh ***
// Constants for the SGMII receive elastic buffer
`ifndef SGMII_EB_CFG_SVH
`define SGMII_EB_CFG_SVH

`define EB_WIDTH 9
`define EB_DEPTH 128
`define EB_AW 7
`define EB_HALF 8'h40
`define EB_DRIFT_BYTES 5000

`define SYM_IDLE 8'hbc
`define SYM_SOP 8'hfb
`define SYM_EOP 8'hfd
`define SYM_ERR 8'hfe

`define REP_1G 7'h01
`define REP_100M 7'h0a
`define REP_10M 7'h64

`define FRAME_STD_MAX 19'h005f2
`define JUMBO_MAX_1G 19'h445c0
`define JUMBO_MAX_100M 19'h06d60
`define JUMBO_MAX_10M 19'h00af0

`endif

// *** pkg/sgmii_eb_pkg.sv ***
// Types for the SGMII receive elastic buffer
package sgmii_eb_pkg;

   typedef enum logic [1:0] {
      ST_GAP = 2'b01,
      ST_FRAME = 2'b10
   } frame_state_t;

   typedef enum logic [2:0] {
      SPEED_1G = 3'b001,
      SPEED_100M = 3'b010,
      SPEED_10M = 3'b100
   } speed_t;

endpackage : sgmii_eb_pkg

// *** hw/elastic_fifo.sv ***
// Gray-pointer FIFO with registered read data and occupancy on the read side
module elastic_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 128,
   parameter int AW = 7
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready,
   // Status
   output logic [AW:0] occupancy
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wbin_r;
   logic [AW:0] wgray_r;
   logic [AW:0] rbin_r;
   logic [AW:0] rgray_r;
   logic [AW:0] wg_s1_r;
   logic [AW:0] wg_s2_r;
   logic [AW:0] rg_s1_r;
   logic [AW:0] rg_s2_r;
   logic [AW:0] wsync_bin;
   logic [AW:0] rsync_bin;
   logic [AW:0] wbin_nxt;
   logic [AW:0] rbin_nxt;
   logic [AW:0] occ_r;
   logic [WIDTH-1:0] out_data_r;
   logic out_valid_r;
   logic wr_en;
   logic rd_en;
   logic empty;

   // Gray to binary for both synchronised pointers
   genvar i;
   generate
      for (i = 0; i <= AW; i++)
      begin : g_g2b
         assign wsync_bin[i] = ^wg_s2_r[AW:i];
         assign rsync_bin[i] = ^rg_s2_r[AW:i];
      end
   endgenerate

   assign wbin_nxt = wbin_r + (AW+1)'(1);
   assign rbin_nxt = rbin_r + (AW+1)'(1);
   assign in_ready = ((wbin_r - rsync_bin) != (AW+1)'(DEPTH));
   assign wr_en = in_valid && in_ready;
   assign empty = (wsync_bin == rbin_r);
   assign rd_en = !empty && (!out_valid_r || out_ready);

   assign out_valid = out_valid_r;
   assign out_data = out_data_r;
   assign occupancy = occ_r;

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wbin_r[AW-1:0]] <= in_data;
      end
   end

   // Write pointer, published in Gray code
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wbin_r <= '0;
         wgray_r <= '0;
      end
      else if (wr_en)
      begin
         wbin_r <= wbin_nxt;
         wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      end
   end

   // Pointer synchronisers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wg_s1_r <= '0;
         wg_s2_r <= '0;
         rg_s1_r <= '0;
         rg_s2_r <= '0;
      end
      else
      begin
         wg_s1_r <= wgray_r;
         wg_s2_r <= wg_s1_r;
         rg_s1_r <= rgray_r;
         rg_s2_r <= rg_s1_r;
      end
   end

   // Read pointer and registered read data
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rbin_r <= '0;
         rgray_r <= '0;
         out_valid_r <= 1'b0;
         out_data_r <= '0;
      end
      else if (rd_en)
      begin
         rbin_r <= rbin_nxt;
         rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
         out_valid_r <= 1'b1;
         out_data_r <= mem[rbin_r[AW-1:0]];
      end
      else if (out_ready)
      begin
         out_valid_r <= 1'b0;
      end
   end

   // Occupancy from the synchronised write pointer
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         occ_r <= '0;
      end
      else
      begin
         occ_r <= wsync_bin - rbin_r;
      end
   end

endmodule : elastic_fifo

// *** dv/link_model.sv ***
// Recovered-link model: one symbol per rec_clk cycle, byte moved on the falling edge
module link_model (
   // Link outputs
   output logic rec_clk,
   output logic [7:0] rx_data,
   output logic rx_is_k
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      rec_clk = 1'b0;
      rx_data = 8'h00;
      rx_is_k = 1'b0;
   end

   // Lower speeds repeat each symbol rep times; clock stands still between calls
   task automatic send(input logic k, input logic [7:0] d, input int rep);
      for (int i = 0; i < rep; i++)
      begin
         rx_is_k = k;
         rx_data = d;
         #80 rec_clk = 1'b1;
         #80 rec_clk = 1'b0;
         // Past hold time the old symbol must not look valid
         rx_is_k = ~k;
         rx_data = ~d;
      end
   endtask : send
endmodule : link_model

// *** dv/eb_checker_assertions.sv ***
// Port-level checks for the SGMII receive elastic buffer
module eb_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link and mode
   input wire logic rec_clk,
   input wire logic [7:0] rx_data,
   input wire logic rx_is_k,
   input wire logic use_xcvr_buffer,
   input wire logic [1:0] speed_sel,
   // MAC side
   input wire logic [7:0] mac_data,
   input wire logic mac_is_k,
   input wire logic mac_valid,
   input wire logic mac_ready,
   // Status
   input wire logic [7:0] eb_occupancy,
   input wire logic [7:0] eb_occ_max,
   input wire logic [7:0] eb_occ_min,
   input wire logic eb_in_frame,
   input wire logic eb_idle_dropped,
   input wire logic eb_overflow,
   input wire logic eb_underflow,
   input wire logic eb_frame_jumbo,
   input wire logic eb_frame_too_long
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   hold_word_a: assert property (
      !use_xcvr_buffer && !$past(use_xcvr_buffer, 4) && mac_valid && !mac_ready
      |=> mac_valid && $stable({mac_is_k, mac_data})) else $error("word not held");
   occ_bound_a: assert property (
      eb_occupancy <= 8'h80 && eb_occ_max <= 8'h80) else $error("occupancy above depth");
   drop_gap_a: assert property (
      eb_idle_dropped |-> !eb_in_frame) else $error("idle dropped in frame");
   drop_level_a: assert property (
      eb_idle_dropped |-> eb_occupancy > 8'h40) else $error("drop below half");
   drop_pair_a: assert property (
      eb_idle_dropped |=> !eb_idle_dropped [*8]) else $error("drops too close");
   ovf_full_a: assert property (
      eb_overflow |-> eb_occupancy >= 8'h70) else $error("overflow while not full");
   jumbo_order_a: assert property (
      eb_frame_too_long |-> eb_frame_jumbo) else $error("too long without jumbo");
   jumbo_clear_a: assert property (
      $rose(eb_in_frame) |-> ##[0:4] !eb_frame_jumbo && !eb_frame_too_long)
      else $error("length flags not cleared");
   water_order_a: assert property (
      eb_in_frame |-> eb_occ_min <= eb_occ_max) else $error("watermarks crossed");
   bypass_pulse_a: assert property (
      use_xcvr_buffer && $past(use_xcvr_buffer, 4) && mac_valid |=> !mac_valid)
      else $error("bypass valid not a pulse");

   cover property (eb_idle_dropped);
   cover property (eb_overflow);
   cover property ($rose(eb_frame_jumbo));
endmodule : eb_checker

// *** dv/tb_top.sv ***
// Self-checking bench for the SGMII receive elastic buffer
`include "sgmii_eb_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic use_xcvr_buffer = 1'b0;
   logic [1:0] speed_sel = 2'h0;
   logic mac_ready = 1'b0;
   logic rec_clk, rx_is_k, mac_is_k, mac_valid, eb_in_frame, eb_idle_dropped;
   logic eb_overflow, eb_underflow, eb_frame_jumbo, eb_frame_too_long;
   logic [7:0] rx_data, mac_data, eb_occupancy, eb_occ_max, eb_occ_min;
   logic [8:0] got[$];
   int bad_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int drops = 0;
   int ovf = 0;
   int unf = 0;

   link_model link_model_i (.rec_clk(rec_clk), .rx_data(rx_data), .rx_is_k(rx_is_k));

   sgmii_rx_elastic_buffer sgmii_rx_elastic_buffer_i (
      .clk(clk), .rst(rst), .rec_clk(rec_clk), .rx_data(rx_data), .rx_is_k(rx_is_k),
      .use_xcvr_buffer(use_xcvr_buffer), .speed_sel(speed_sel), .mac_data(mac_data),
      .mac_is_k(mac_is_k), .mac_valid(mac_valid), .mac_ready(mac_ready),
      .eb_occupancy(eb_occupancy), .eb_occ_max(eb_occ_max), .eb_occ_min(eb_occ_min),
      .eb_in_frame(eb_in_frame), .eb_idle_dropped(eb_idle_dropped),
      .eb_overflow(eb_overflow), .eb_underflow(eb_underflow),
      .eb_frame_jumbo(eb_frame_jumbo), .eb_frame_too_long(eb_frame_too_long));

   initial
   begin
      forever #5 clk = ~clk;
   end

   // Collect accepted words, count pulses, cut a hang short
   always @(posedge clk)
   begin
      cyc++;
      if (mac_valid === 1'b1 && (mac_ready || use_xcvr_buffer))
         got.push_back({mac_is_k, mac_data});
      if (eb_idle_dropped === 1'b1)
         drops++;
      if (eb_overflow === 1'b1)
         ovf++;
      if (eb_underflow === 1'b1)
         unf++;
      if (cyc == 60000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic sym(input logic [8:0] w);
      link_model_i.send(w[8], w[7:0], 1);
   endtask : sym

   task automatic drain;
      mac_ready = 1'b1;
      for (int k = 0; k < 3000 && !(eb_occupancy === 8'h00 && mac_valid === 1'b0); k++)
         tick(1);
      tick(10);
      check("drained", 8'h00, eb_occupancy);
   endtask : drain

   task automatic frame_pass;
      int n = -1;
      got.delete();
      drain();
      repeat (4) sym(9'h1bc);
      sym(9'h1fb);
      for (int i = 0; i < 20; i++)
         sym({1'b0, i[7:0]});
      tick(1);
      check("in_frame", 1'b1, eb_in_frame);
      sym(9'h1fd);
      repeat (2) sym(9'h1bc);
      drain();
      check("in_frame", 1'b0, eb_in_frame);
      foreach (got[k])
         if (got[k] === 9'h1fb && n < 0)
            n = k;
      check("sop_pos", 1'b1, n >= 0 && n + 21 < got.size());
      if (n >= 0 && n + 21 < got.size())
         for (int i = 0; i <= 20; i++)
            check("frame_word", i < 20 ? i : 9'h1fd, got[n + 1 + i]);
   endtask : frame_pass

   task automatic fill_gap;
      drops = 0;
      mac_ready = 1'b0;
      repeat (100) sym(9'h1bc);
      tick(20);
      check("gap_occ", 1'b1, eb_occupancy > `EB_HALF && eb_occupancy <= `EB_HALF + 2);
      check("gap_drops", 1'b1, drops >= 16 && drops <= 18);
      drain();
   endtask : fill_gap

   task automatic overflow;
      repeat (2) sym(9'h1bc);
      tick(20);
      got.delete();
      ovf = 0;
      unf = 0;
      mac_ready = 1'b0;
      sym(9'h1fb);
      for (int i = 0; i < 140; i++)
         sym({1'b0, i[7:0]});
      tick(20);
      check("full_occ", 1'b1, eb_occupancy >= 8'h7c);
      check("occ_max", 1'b1, eb_occ_max >= 8'h7c);
      check("ovf_seen", 1'b1, ovf > 0);
      check("occ_min", 1'b1, eb_occ_min <= 8'h02);
      check("no_underflow", 0, unf);
      drain();
      check("kept_words", 141, got.size() + ovf);
      check("first_word", 9'h1fb, got[0]);
      sym(9'h1fd);
      tick(20);
   endtask : overflow

   task automatic speed_rep;
      int n;
      for (int s = 1; s <= 2; s++)
      begin
         speed_sel = s[1:0];
         got.delete();
         sym(9'h1fb);
         link_model_i.send(1'b0, 8'h5a, s == 1 ? 10 : 100);
         sym(9'h1fd);
         drain();
         n = 0;
         foreach (got[k])
            n += (got[k] === 9'h05a);
         check("replicas", s == 1 ? 10 : 100, n);
         check("jumbo_low", 1'b0, eb_frame_jumbo);
      end
      speed_sel = 2'h0;
   endtask : speed_rep

   task automatic jumbo;
      mac_ready = 1'b1;
      sym(9'h1fb);
      // Frame kept far below the 1 Gbps jumbo limit
      for (int i = 0; i < 1525; i++)
      begin
         sym({1'b0, i[7:0]});
         if (i == 1521)
            check("jumbo_std", 1'b0, eb_frame_jumbo);
         if (i == 1522)
            check("jumbo_edge", 1'b1, eb_frame_jumbo);
      end
      tick(10);
      check("jumbo_set", 1'b1, eb_frame_jumbo);
      check("too_long", 1'b0, eb_frame_too_long);
      sym(9'h1fd);
      sym(9'h1fb);
      tick(10);
      check("jumbo_clr", 1'b0, eb_frame_jumbo);
      sym(9'h1fd);
      drain();
   endtask : jumbo

   task automatic bypass;
      logic [8:0] w[3] = '{9'h055, 9'h0aa, 9'h1bc};
      use_xcvr_buffer = 1'b1;
      mac_ready = 1'b0;
      tick(4);
      got.delete();
      foreach (w[k])
         sym(w[k]);
      tick(10);
      check("byp_count", 3, got.size());
      foreach (w[k])
         check("byp_word", w[k], got[k]);
      use_xcvr_buffer = 1'b0;
      drain();
   endtask : bypass

   task automatic end_of_test;
      $display("Mismatches %0d of %0d comparisons", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      tick(8);
      rst = 1'b0;
      tick(4);
      frame_pass();
      fill_gap();
      overflow();
      speed_rep();
      jumbo();
      bypass();
      end_of_test();
   end
endmodule : tb_top

bind sgmii_rx_elastic_buffer eb_checker eb_checker_i (.*);
